/* hdl/adc_cal_pkg.sv */
// constants, field layout and state encodings for the adc calibration control block
package adc_cal_pkg;
  // register map
  localparam logic [7:0] CAL_CTRL_ADDR = 8'hf5;
  localparam logic [7:0] CAL_CTRL_RESET = 8'h00;
  localparam int BUSY_BIT = 7;
  localparam int GAIN_DIS_BIT = 6;
  localparam int AVG_HI_BIT = 5;
  localparam int AVG_LO_BIT = 4;
  localparam int OFFSET_DIS_BIT = 3;
  localparam int MODE_BIT = 2;
  localparam int TYPE_BIT = 1;
  localparam int START_BIT = 0;

  // converter geometry
  localparam int RES_W = 12;
  localparam logic [3:0] RES_MSB = 4'hb;
  localparam logic [3:0] BIT_STEPS = 4'hc;
  localparam logic [3:0] CONV_TICKS = 4'hf;
  localparam logic [11:0] FULL_SCALE = 12'h0fff;
  localparam logic [11:0] ZERO_CODE = 12'h000;

  // readings per bit decision
  localparam logic [5:0] AVG_NONE = 6'h01;
  localparam logic [5:0] AVG_COUNT_00 = 6'h0f;
  localparam logic [5:0] AVG_COUNT_01 = 6'h1f;
  localparam logic [5:0] AVG_COUNT_10 = 6'h2f;
  localparam logic [5:0] AVG_COUNT_11 = 6'h3f;

  // core clocks per conversion clock, by divider select code
  localparam logic [5:0] DIV_SEL_00 = 6'h08;
  localparam logic [5:0] DIV_SEL_01 = 6'h04;
  localparam logic [5:0] DIV_SEL_10 = 6'h10;
  localparam logic [5:0] DIV_SEL_11 = 6'h20;

  typedef enum logic [3:0] {
    ENG_IDLE = 4'b0001,
    ENG_SYNC = 4'b0010,
    ENG_ACQ = 4'b0100,
    ENG_CONV = 4'b1000
  } eng_state_t;

  typedef enum logic [2:0] {
    CTL_IDLE = 3'b001,
    CTL_CONV = 3'b010,
    CTL_CAL = 3'b100
  } ctl_state_t;
endpackage : adc_cal_pkg

/* hdl/sar_engine.sv */
// successive-approximation sequencer: sync, track, hold and bit decisions
`timescale 1ns/1ns
`default_nettype none
module sar_engine
  import adc_cal_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic conv_tick,
  input wire logic start,
  input wire logic [2:0] acq_ticks,
  input wire logic [5:0] avg_count,
  input wire logic comp_hi,
  output logic busy,
  output logic done,
  output logic [11:0] code,
  output logic [11:0] dac_code,
  output logic sample_switch_a,
  output logic sample_switch_b
);
  eng_state_t state_ff;
  logic [3:0] step_ff;
  logic [5:0] rd_ff;
  logic [5:0] vote_ff;
  logic [2:0] acq_ff;
  logic [11:0] sar_ff;
  logic [11:0] code_ff;
  logic done_ff;

  wire logic [3:0] bit_idx = RES_MSB - step_ff;
  wire logic deciding = (state_ff == ENG_CONV) && (step_ff < BIT_STEPS);
  wire logic last_read = (rd_ff == avg_count - 6'h01);
  wire logic [5:0] vote_next = vote_ff + {5'h00, comp_hi};
  // majority over the readings of one bit decision
  wire logic keep_bit = {vote_next, 1'b0} > {1'b0, avg_count};

  // trial code: decided bits plus the bit under test
  genvar i;
  generate
    for (i = 0; i < RES_W; i++) begin : g_trial
      assign dac_code[i] = sar_ff[i] | (deciding && (bit_idx == 4'(i)));
    end
  endgenerate

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      state_ff <= ENG_IDLE;
      step_ff <= 4'h0;
      rd_ff <= 6'h00;
      vote_ff <= 6'h00;
      acq_ff <= 3'h0;
      sar_ff <= ZERO_CODE;
      code_ff <= ZERO_CODE;
      done_ff <= 1'b0;
    end else if (clk_en) begin
      done_ff <= 1'b0;
      case (state_ff)
        ENG_IDLE: begin
          if (start) begin
            state_ff <= ENG_SYNC;
            sar_ff <= ZERO_CODE;
          end
        end
        ENG_SYNC: begin
          if (conv_tick) begin
            state_ff <= ENG_ACQ;
            acq_ff <= 3'h1;
          end
        end
        ENG_ACQ: begin
          if (conv_tick) begin
            if (acq_ff == acq_ticks) begin
              state_ff <= ENG_CONV;
              step_ff <= 4'h0;
              rd_ff <= 6'h00;
              vote_ff <= 6'h00;
            end else begin
              acq_ff <= acq_ff + 3'h1;
            end
          end
        end
        ENG_CONV: begin
          if (conv_tick) begin
            if (deciding) begin
              if (last_read) begin
                sar_ff[bit_idx] <= keep_bit;
                step_ff <= step_ff + 4'h1;
                rd_ff <= 6'h00;
                vote_ff <= 6'h00;
              end else begin
                rd_ff <= rd_ff + 6'h01;
                vote_ff <= vote_next;
              end
            end else if (step_ff == CONV_TICKS - 4'h1) begin
              code_ff <= sar_ff;
              done_ff <= 1'b1;
              state_ff <= ENG_IDLE;
            end else begin
              step_ff <= step_ff + 4'h1;
            end
          end
        end
        default: state_ff <= ENG_IDLE;
      endcase
    end
  end

  assign busy = (state_ff != ENG_IDLE);
  assign done = done_ff;
  assign code = code_ff;
  // both switches track outside the hold phase
  assign sample_switch_a = (state_ff != ENG_CONV);
  assign sample_switch_b = (state_ff != ENG_CONV);
endmodule : sar_engine
`default_nettype wire

/* hdl/sar_adc_calibration_control.sv */
// calibration control register, conversion sequencing and coefficient correction
//
// Notes on behaviour
// - bit 7 reads busy for every conversion or calibration cycle, software cannot write it
// - busy falls by itself when the running cycle ends
// - bit 6 low applies the gain coefficient to results, high bypasses it
// - bits 5:4 pick readings per bit decision in calibration, 00 is 15, 11 is 63
// - bit 3 low applies the offset coefficient to results, high bypasses it
// - bit 1 low means offset calibration, high means gain calibration
// - writing one to bit 0 starts calibration of the chosen type and averaging
// - bit 0 clears itself when the launched calibration finishes
// - register resets to all zeros, nothing running
// - each conversion tracks the input, then holds while the sar steps the dac
// - sar contents at end of hold become the conversion result
// - sequencing and acquisition and conversion timing run automatically from settings
// - conversion proper takes 15 conversion clocks after sync and acquisition
// - single conversion request clears itself when the result updates
`timescale 1ns/1ns
`default_nettype none
module sar_adc_calibration_control
  import adc_cal_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [1:0] conv_clk_sel,
  input wire logic [1:0] acq_sel,
  input wire logic conv_req,
  output logic single_conversion_request,
  input wire logic comp_pin,
  output logic [11:0] dac_code,
  output logic sample_switch_a,
  output logic sample_switch_b,
  output logic cal_ref_zero,
  output logic cal_ref_full,
  output logic [11:0] result_data,
  output logic result_valid,
  output logic busy
);
  // register fields
  logic gain_coeff_disable_ff;
  logic average_count_sel_hi_ff;
  logic average_count_sel_lo_ff;
  logic offset_coeff_disable_ff;
  logic calibration_mode_select_ff;
  logic calibration_type_select_ff;
  logic start_calibration_ff;
  logic single_conversion_request_ff;

  // sequencing and storage
  ctl_state_t ctl_ff;
  logic cal_type_ff;
  logic [5:0] avg_ff;
  logic [5:0] div_cnt_ff;
  logic comp_meta_ff;
  logic comp_sync_ff;
  logic [11:0] offset_coeff_ff;
  logic [11:0] gain_err_ff;
  logic [11:0] result_ff;
  logic result_valid_ff;
  logic [7:0] rdata_ff;

  // engine connections
  logic eng_busy;
  logic eng_done;
  logic [11:0] eng_code;

  // bus decode
  wire logic wr_hit = sfr_wr && (sfr_addr == CAL_CTRL_ADDR);
  wire logic rd_hit = sfr_rd && (sfr_addr == CAL_CTRL_ADDR);

  // conversion clock divider; only the tick leaves this block, no second domain
  wire logic [5:0] div_limit =
    (conv_clk_sel == 2'b00) ? DIV_SEL_00 :
    (conv_clk_sel == 2'b01) ? DIV_SEL_01 :
    (conv_clk_sel == 2'b10) ? DIV_SEL_10 : DIV_SEL_11;
  wire logic conv_tick = (div_cnt_ff >= div_limit - 6'h01);
  wire logic [5:0] nxt_div_cnt = conv_tick ? 6'h00 : div_cnt_ff + 6'h01;

  // acquisition lasts one to four conversion clocks
  wire logic [2:0] acq_ticks = {1'b0, acq_sel} + 3'h1;

  // averaging count for the next calibration
  wire logic [1:0] avg_code = {average_count_sel_hi_ff, average_count_sel_lo_ff};
  wire logic [5:0] avg_lookup =
    (avg_code == 2'b00) ? AVG_COUNT_00 :
    (avg_code == 2'b01) ? AVG_COUNT_01 :
    (avg_code == 2'b10) ? AVG_COUNT_10 : AVG_COUNT_11;

  // launch: a pending calibration goes before a pending conversion
  wire logic ctl_idle = (ctl_ff == CTL_IDLE);
  wire logic launch_cal = ctl_idle && !eng_busy && start_calibration_ff;
  wire logic launch_conv = ctl_idle && !eng_busy && !start_calibration_ff && single_conversion_request_ff;
  wire logic eng_start = launch_cal || launch_conv;
  wire logic cal_done = (ctl_ff == CTL_CAL) && eng_done;
  wire logic conv_done = (ctl_ff == CTL_CONV) && eng_done;

  wire logic [5:0] nxt_avg = launch_cal ? avg_lookup : (launch_conv ? AVG_NONE : avg_ff);

  // a set beats a same-cycle hardware clear for both self-clearing bits
  wire logic nxt_start_cal =
    (wr_hit && sfr_wdata[START_BIT]) || (start_calibration_ff && !cal_done);
  wire logic nxt_single_conversion_request = conv_req || (single_conversion_request_ff && !conv_done);

  ctl_state_t nxt_ctl;
  assign nxt_ctl =
    launch_cal ? CTL_CAL :
    launch_conv ? CTL_CONV :
    (eng_done && !ctl_idle) ? CTL_IDLE : ctl_ff;

  // offset correction, clamped at zero so a small input cannot wrap
  wire logic [11:0] offset_eff = offset_coeff_disable_ff ? ZERO_CODE : offset_coeff_ff;
  wire logic [11:0] x_off = (eng_code >= offset_eff) ? (eng_code - offset_eff) : ZERO_CODE;

  // gain correction as a fractional boost: x + x*err/4096, saturated at full scale
  wire logic [11:0] gain_eff = gain_coeff_disable_ff ? ZERO_CODE : gain_err_ff;
  wire logic [23:0] gain_prod = x_off * gain_eff;
  wire logic [12:0] gain_sum = {1'b0, x_off} + {1'b0, gain_prod[23:12]};
  wire logic [11:0] corrected = gain_sum[12] ? FULL_SCALE : gain_sum[11:0];

  // coefficient update; gain is measured after offset removal
  wire logic [11:0] nxt_offset_coeff =
    (cal_done && !cal_type_ff) ? eng_code : offset_coeff_ff;
  wire logic [11:0] nxt_gain_err =
    (cal_done && cal_type_ff) ? (FULL_SCALE - x_off) : gain_err_ff;

  wire logic busy_flag = !ctl_idle;
  wire logic [7:0] reg_view = {
    busy_flag,
    gain_coeff_disable_ff,
    average_count_sel_hi_ff,
    average_count_sel_lo_ff,
    offset_coeff_disable_ff,
    calibration_mode_select_ff,
    calibration_type_select_ff,
    start_calibration_ff
  };
  // other addresses answer zero so several slaves can share the read path
  wire logic [7:0] nxt_rdata = rd_hit ? reg_view : CAL_CTRL_RESET;

  // comparator pin is outside the clock domain
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      comp_meta_ff <= 1'b0;
      comp_sync_ff <= 1'b0;
    end else if (clk_en) begin
      comp_meta_ff <= comp_pin;
      comp_sync_ff <= comp_meta_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      gain_coeff_disable_ff <= CAL_CTRL_RESET[GAIN_DIS_BIT];
      average_count_sel_hi_ff <= CAL_CTRL_RESET[AVG_HI_BIT];
      average_count_sel_lo_ff <= CAL_CTRL_RESET[AVG_LO_BIT];
      offset_coeff_disable_ff <= CAL_CTRL_RESET[OFFSET_DIS_BIT];
      calibration_mode_select_ff <= CAL_CTRL_RESET[MODE_BIT];
      calibration_type_select_ff <= CAL_CTRL_RESET[TYPE_BIT];
    end else if (clk_en && wr_hit) begin
      gain_coeff_disable_ff <= sfr_wdata[GAIN_DIS_BIT];
      average_count_sel_hi_ff <= sfr_wdata[AVG_HI_BIT];
      average_count_sel_lo_ff <= sfr_wdata[AVG_LO_BIT];
      offset_coeff_disable_ff <= sfr_wdata[OFFSET_DIS_BIT];
      calibration_mode_select_ff <= sfr_wdata[MODE_BIT];
      calibration_type_select_ff <= sfr_wdata[TYPE_BIT];
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      start_calibration_ff <= CAL_CTRL_RESET[START_BIT];
      single_conversion_request_ff <= 1'b0;
      ctl_ff <= CTL_IDLE;
      avg_ff <= AVG_NONE;
      div_cnt_ff <= 6'h00;
    end else if (clk_en) begin
      start_calibration_ff <= nxt_start_cal;
      single_conversion_request_ff <= nxt_single_conversion_request;
      ctl_ff <= nxt_ctl;
      avg_ff <= nxt_avg;
      div_cnt_ff <= nxt_div_cnt;
    end
  end

  // type is frozen at launch so a rewrite mid-cycle cannot retarget the coefficient
  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      cal_type_ff <= 1'b0;
    end else if (clk_en && launch_cal) begin
      cal_type_ff <= calibration_type_select_ff;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      offset_coeff_ff <= ZERO_CODE;
      gain_err_ff <= ZERO_CODE;
    end else if (clk_en) begin
      offset_coeff_ff <= nxt_offset_coeff;
      gain_err_ff <= nxt_gain_err;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!rst_n) begin
      result_ff <= ZERO_CODE;
      result_valid_ff <= 1'b0;
      rdata_ff <= CAL_CTRL_RESET;
    end else if (clk_en) begin
      result_valid_ff <= conv_done;
      if (conv_done) begin
        result_ff <= corrected;
      end
      rdata_ff <= nxt_rdata;
    end
  end

  sar_engine u_engine (
    .core_clk(core_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .conv_tick(conv_tick),
    .start(eng_start),
    .acq_ticks(acq_ticks),
    .avg_count(avg_ff),
    .comp_hi(comp_sync_ff),
    .busy(eng_busy),
    .done(eng_done),
    .code(eng_code),
    .dac_code(dac_code),
    .sample_switch_a(sample_switch_a),
    .sample_switch_b(sample_switch_b)
  );

  // reference steering only when software has armed calibration mode
  assign cal_ref_zero = (ctl_ff == CTL_CAL) && calibration_mode_select_ff && !cal_type_ff;
  assign cal_ref_full = (ctl_ff == CTL_CAL) && calibration_mode_select_ff && cal_type_ff;

  assign sfr_rdata = rdata_ff;
  assign single_conversion_request = single_conversion_request_ff;
  assign result_data = result_ff;
  assign result_valid = result_valid_ff;
  assign busy = busy_flag;
endmodule : sar_adc_calibration_control
`default_nettype wire

/* dv/adc_cal_checker.sv */
// port-level assertions for the adc calibration control block
`timescale 1ns/1ns
`default_nettype none
module adc_cal_checker
  import adc_cal_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  input wire logic [7:0] sfr_rdata,
  input wire logic conv_req,
  input wire logic single_conversion_request,
  input wire logic sample_switch_a,
  input wire logic sample_switch_b,
  input wire logic cal_ref_zero,
  input wire logic cal_ref_full,
  input wire logic [11:0] result_data,
  input wire logic result_valid,
  input wire logic busy
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  wire logic hit = sfr_addr == CAL_CTRL_ADDR;
  chk_start_busy:
    assert property (clk_en && sfr_wr && hit && sfr_wdata[START_BIT] && !busy
      && !single_conversion_request |=> ##1 busy) else $error("start did not raise busy");
  chk_busy_read:
    assert property (clk_en && sfr_rd && hit |=> sfr_rdata[BUSY_BIT] == $past(busy))
      else $error("read busy bit differs from busy");
  chk_rdata_idle:
    assert property (clk_en && !(sfr_rd && hit) |=> sfr_rdata == 8'h00)
      else $error("read data not zero without a read");
  chk_flag_set:
    assert property (clk_en && conv_req |=> single_conversion_request)
      else $error("request flag not set");
  chk_flag_clear:
    assert property (result_valid && !$past(conv_req) |-> !single_conversion_request)
      else $error("request flag still set at result");
  chk_done_pulse:
    assert property (result_valid |-> !busy && $past(busy) ##1 !result_valid)
      else $error("result pulse not at end of busy");
  chk_hold_busy:
    assert property (!(sample_switch_a && sample_switch_b) |-> busy && !sample_switch_a
      && !sample_switch_b) else $error("switches in hold outside a cycle");
  chk_ref_type:
    assert property (cal_ref_zero || cal_ref_full |-> busy && !(cal_ref_zero && cal_ref_full))
      else $error("calibration reference out of cycle");
  chk_result_hold:
    assert property ($changed(result_data) |-> result_valid)
      else $error("result changed without a result pulse");
  chk_busy_min:
    assert property ($rose(busy) |-> busy[*8]) else $error("busy too short");
endmodule : adc_cal_checker

bind sar_adc_calibration_control adc_cal_checker adc_cal_checker_inst (.core_clk, .rst_n,
  .clk_en, .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata, .conv_req,
  .single_conversion_request, .sample_switch_a, .sample_switch_b, .cal_ref_zero,
  .cal_ref_full, .result_data, .result_valid, .busy);
`default_nettype wire

/* dv/tb_top.sv */
// self-checking bench for the adc calibration control block
`timescale 1ns/1ns
`default_nettype none
module tb_top
  import adc_cal_pkg::*;
;
  logic core_clk, rst_n, sfr_wr, sfr_rd, conv_req, single_conversion_request, comp_pin;
  logic [7:0] sfr_addr, sfr_wdata, sfr_rdata;
  logic [11:0] dac_code, result_data, vin, eff;
  logic sample_switch_a, sample_switch_b, cal_ref_zero, cal_ref_full, result_valid, busy;
  int err_total, checked;
  // references give fixed codes so the stored coefficients are predictable
  assign eff = cal_ref_zero ? 12'h100 : (cal_ref_full ? 12'hf00 : vin);
  assign comp_pin = eff >= dac_code;
  sar_adc_calibration_control sar_adc_calibration_control_inst (.core_clk, .rst_n,
    .clk_en(1'b1), .sfr_addr, .sfr_wr, .sfr_rd, .sfr_wdata, .sfr_rdata,
    .conv_clk_sel(2'b01), .acq_sel(2'b00), .conv_req, .single_conversion_request, .comp_pin,
    .dac_code, .sample_switch_a, .sample_switch_b, .cal_ref_zero, .cal_ref_full,
    .result_data, .result_valid, .busy);
  initial begin
    core_clk = 1'b0;
    forever #20 core_clk = ~core_clk;
  end
  task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
    checked++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    sfr_addr = a;
    sfr_wdata = d;
    sfr_wr = 1'b1;
    @(negedge core_clk);
    sfr_wr = 1'b0;
    @(negedge core_clk);
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    sfr_addr = a;
    sfr_rd = 1'b1;
    @(negedge core_clk);
    sfr_rd = 1'b0;
    d = sfr_rdata;
    @(negedge core_clk);
  endtask : rd
  // bounded so a stuck busy cannot hang the run
  task automatic idle(output int n);
    n = 0;
    while (busy && n < 20000) begin
      @(negedge core_clk);
      n++;
    end
  endtask : idle
  task automatic t_reset();
    logic [7:0] r;
    rd(CAL_CTRL_ADDR, r);
    chk({4'h0, r}, 12'h000);
    chk({11'h000, busy}, 12'h000);
    chk({10'h000, sample_switch_a, sample_switch_b}, 12'h003);
    $display("reset test done");
  endtask : t_reset
  task automatic t_reg();
    logic [7:0] r;
    wr(CAL_CTRL_ADDR, 8'hf8);
    rd(CAL_CTRL_ADDR, r);
    chk({4'h0, r}, 12'h078);
    wr(8'hf4, 8'hff);
    rd(8'hf4, r);
    chk({4'h0, r}, 12'h000);
    rd(CAL_CTRL_ADDR, r);
    chk({4'h0, r}, 12'h078);
    wr(CAL_CTRL_ADDR, 8'h00);
    $display("register test done");
  endtask : t_reg
  task automatic t_conv(input logic [7:0] ctrl, input logic [11:0] x, input logic [11:0] exp);
    int n;
    wr(CAL_CTRL_ADDR, ctrl);
    vin = x;
    conv_req = 1'b1;
    @(negedge core_clk);
    conv_req = 1'b0;
    @(negedge core_clk);
    idle(n);
    chk(result_data, exp);
    chk({11'h000, single_conversion_request}, 12'h000);
    chk(12'(n >= 60 && n <= 72), 12'h001);
    $display("conversion test done");
  endtask : t_conv
  task automatic t_cal(input logic [7:0] ctrl, input int navg);
    int n;
    logic [7:0] r;
    wr(CAL_CTRL_ADDR, ctrl | 8'h01);
    rd(CAL_CTRL_ADDR, r);
    chk({4'h0, r}, {4'h0, ctrl | 8'h81});
    idle(n);
    rd(CAL_CTRL_ADDR, r);
    chk({4'h0, r}, {4'h0, ctrl});
    // a few cycles are spent in the bus tasks before counting starts
    chk(12'(n >= 4 * (12 * navg + 4) - 8 && n <= 4 * (12 * navg + 5) + 4), 12'h001);
    $display("calibration test done");
  endtask : t_cal
  task automatic results();
    $display("checks %0d, mismatches %0d", checked, err_total);
    if (err_total == 0 && checked > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : results
  initial begin
    #(40 * 40000);
    err_total++;
    results();
  end
  initial begin
    rst_n = 1'b0;
    sfr_addr = 8'h00;
    sfr_wdata = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    conv_req = 1'b0;
    vin = 12'h000;
    err_total = 0;
    checked = 0;
    repeat (8) @(negedge core_clk);
    rst_n = 1'b1;
    t_reset();
    t_reg();
    t_conv(8'h48, 12'h400, 12'h400);
    for (int k = 0; k < 4; k++) begin
      t_cal(8'(k << 4) | 8'h04, 15 + 16 * k);
    end
    t_cal(8'h06, 15);
    t_conv(8'h40, 12'h400, 12'h300);
    // gain error 0x1ff from 0xf00 - 0x100, so 0x400 gains 0x07f
    t_conv(8'h08, 12'h400, 12'h47f);
    results();
  end
endmodule : tb_top
`default_nettype wire
